// ===== hw/tpu_pkg.sv
// Purpose: shared constants and types for the five-channel timer pulse unit
// Assumes: 8-bit Avalon-MM byte addresses, 16-bit registers in the low half of the 32-bit data word
// Notes: channel register block sits at (ch+2)*0x20, selected by address[7:5], register within it by address[4:2]
package tpu_pkg;
   localparam int NCH = 5;
   localparam int CW = 16;
   localparam int NIRQ = 3 * NCH;

   // global register byte offsets
   localparam logic [7:0] ADDR_START = 8'h00;
   localparam logic [7:0] ADDR_SYNC = 8'h04;
   localparam logic [7:0] ADDR_MODE = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0c;
   localparam logic [7:0] ADDR_MASK = 8'h10;
   // channel block: address[7:5] = ch + CH_BLK_BASE
   localparam int CH_BLK_BASE = 2;
   localparam logic [2:0] SEL_CTRL = 3'h0;
   localparam logic [2:0] SEL_CNT = 3'h1;
   localparam logic [2:0] SEL_GRA = 3'h2;
   localparam logic [2:0] SEL_GRB = 3'h3;
   localparam logic [2:0] SEL_BRA = 3'h4;
   localparam logic [2:0] SEL_BRB = 3'h5;

   // count clock sources (bit 2 set selects an external pin)
   localparam logic [2:0] CLK_PHI = 3'h0;
   localparam logic [2:0] CLK_EXT_A = 3'h4;

   // general register pin function
   localparam logic [2:0] IO_OFF = 3'h0;
   localparam logic [2:0] IO_OUT0 = 3'h1;
   localparam logic [2:0] IO_OUT1 = 3'h2;
   localparam logic [2:0] IO_TOG = 3'h3;
   localparam logic [2:0] IO_CAP_R = 3'h4;
   localparam logic [2:0] IO_CAP_F = 3'h5;
   localparam logic [2:0] IO_CAP_B = 3'h6;

   // counter clear source
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_A = 2'h1;
   localparam logic [1:0] CLR_B = 2'h2;

   // status bit positions inside each channel's group of three
   localparam int ST_A = 0;
   localparam int ST_B = 1;
   localparam int ST_OVF = 2;

   // reset values
   localparam logic [CW-1:0] GR_RST = 16'hffff;
   localparam logic [CW-1:0] CNT_RST = 16'h0000;

   typedef struct packed {
      logic pwm;
      logic [1:0] clr;
      logic [2:0] io_b;
      logic [2:0] io_a;
      logic [2:0] clk;
   } tpu_chctl_t;

   typedef struct packed {
      logic [7:0] dead;
      logic [3:0] buf_en;
      logic cmpl;
      logic rsync;
      logic phase;
   } tpu_mode_t;

   localparam int CTL_W = $bits(tpu_chctl_t);
   localparam int MODE_W = $bits(tpu_mode_t);
endpackage

// ===== hw/tpu_timer_pulse_unit.sv
// Purpose: five-channel 16-bit timer pulse unit with Avalon-MM register slave
// Assumes: all pin inputs synchronous to clk_sys; one clock, 125 MHz
// Notes: phi is clk_sys; slower count rates are enable pulses from a prescaler
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module tpu_timer_pulse_unit import tpu_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // external count clocks
   input wire logic ext_clock_in_a,
   input wire logic ext_clock_in_b,
   input wire logic ext_clock_in_c,
   input wire logic ext_clock_in_d,
   // capture/compare pins, bit n is channel n
   input wire logic [NCH-1:0] capture_compare_pin_a_i,
   output logic [NCH-1:0] capture_compare_pin_a_o,
   output logic [NCH-1:0] capture_compare_pin_a_oe,
   input wire logic [NCH-1:0] capture_compare_pin_b_i,
   output logic [NCH-1:0] capture_compare_pin_b_o,
   output logic [NCH-1:0] capture_compare_pin_b_oe,
   // channel 4 inverted outputs
   output logic ch4_inverted_out_a,
   output logic ch4_inverted_out_b,
   // interrupts, dma and pattern triggers
   output logic irq,
   output logic [NIRQ-1:0] irq_vec,
   output logic [3:0] dma_req,
   output logic [3:0] pattern_trig
);

   logic waitreq_r;
   logic [31:0] rdata_r;
   logic [NCH-1:0] start_r;
   logic [NCH-1:0] sync_r;
   tpu_mode_t mode_r;
   logic [NIRQ-1:0] stat_r;
   logic [NIRQ-1:0] stat_nxt;
   logic [NIRQ-1:0] mask_r;
   logic [NIRQ-1:0] ev;
   logic [2:0] presc_r;
   logic [3:0] pre_en;
   logic [3:0] ext_now;
   logic [3:0] ext_prev_r;
   logic [3:0] ext_rise;
   logic q_chg;
   logic q_up;
   logic acc;
   logic go_wr;
   logic full16;
   logic [NCH-1:0] hit;
   logic [2:0] sel;
   logic [31:0] rd_nxt;
   logic sync_hit_cnt;
   logic sync_clr;
   logic [CW:0] c3;
   logic [CW:0] dz;
   logic [2:0] pos;
   logic [2:0] neg;
   logic special;

   wire [CW-1:0] cnt_w [NCH];
   wire [CW-1:0] gra_w [NCH];
   wire [CW-1:0] grb_w [NCH];
   wire [CW-1:0] bra_w [NCH];
   wire [CW-1:0] brb_w [NCH];
   wire [CTL_W-1:0] ctl_w [NCH];
   wire [NCH-1:0] evt_a;
   wire [NCH-1:0] evt_b;
   wire [NCH-1:0] ovf_e;
   wire [NCH-1:0] clr_e;
   wire [NCH-1:0] pa_s;
   wire [NCH-1:0] pb_s;
   wire [NCH-1:0] oea_s;
   wire [NCH-1:0] oeb_s;

   // capture edge test for one pin function
   function automatic logic cap_hit(input logic [2:0] io, input logic cur, input logic prev);
      logic r;
      r = 1'b0;
      case (io)
         IO_CAP_R: r = cur & ~prev;
         IO_CAP_F: r = ~cur & prev;
         IO_CAP_B: r = cur ^ prev;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // bus handshake: request seen with waitrequest high, answered next cycle
   assign acc = (avs_read | avs_write) & waitreq_r;
   assign go_wr = avs_write & ~waitreq_r;
   assign full16 = avs_byteenable[0] & avs_byteenable[1]; // whole 16-bit words only
   assign sel = avs_address[4:2];

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         hit[c] = (avs_address[7:5] == 3'(c + CH_BLK_BASE));
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         waitreq_r <= 1'b1;
         rdata_r <= 32'h0;
      end else begin
         waitreq_r <= ~acc;
         if (acc) begin
            rdata_r <= rd_nxt;
         end
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_nxt = 32'h0;
      case (avs_address)
         ADDR_START: rd_nxt = {27'h0, start_r};
         ADDR_SYNC: rd_nxt = {27'h0, sync_r};
         ADDR_MODE: rd_nxt = {17'h0, mode_r};
         ADDR_STAT: rd_nxt = {17'h0, stat_r};
         ADDR_MASK: rd_nxt = {17'h0, mask_r};
         default: rd_nxt = 32'h0;
      endcase
      for (int c = 0; c < NCH; c++) begin
         if (hit[c]) begin
            case (sel)
               SEL_CTRL: rd_nxt = {20'h0, ctl_w[c]};
               SEL_CNT: rd_nxt = {16'h0, cnt_w[c]};
               SEL_GRA: rd_nxt = {16'h0, gra_w[c]};
               SEL_GRB: rd_nxt = {16'h0, grb_w[c]};
               SEL_BRA: rd_nxt = {16'h0, bra_w[c]};
               SEL_BRB: rd_nxt = {16'h0, brb_w[c]};
               default: rd_nxt = 32'h0;
            endcase
         end
      end
   end

   // global control registers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         start_r <= '0;
         sync_r <= '0;
         mode_r <= '0;
         mask_r <= '0;
      end else if (go_wr && full16) begin
         case (avs_address)
            ADDR_START: start_r <= avs_writedata[NCH-1:0];
            ADDR_SYNC: sync_r <= avs_writedata[NCH-1:0];
            ADDR_MODE: mode_r <= tpu_mode_t'(avs_writedata[MODE_W-1:0]);
            ADDR_MASK: mask_r <= avs_writedata[NIRQ-1:0];
            default: ;
         endcase
      end
   end

   // prescaler enables for phi, phi/2, phi/4, phi/8
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         presc_r <= 3'h0;
      end else begin
         presc_r <= presc_r + 3'h1;
      end
   end

   assign pre_en = {presc_r == 3'h7, presc_r[1:0] == 2'h3, presc_r[0], 1'b1};

   // external pin history for clock edges and quadrature decode
   assign ext_now = {ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a};

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ext_prev_r <= 4'h0;
      end else begin
         ext_prev_r <= ext_now;
      end
   end

   assign ext_rise = ext_now & ~ext_prev_r;
   assign q_chg = (ext_now[0] ^ ext_prev_r[0]) | (ext_now[1] ^ ext_prev_r[1]);
   assign q_up = ~(ext_prev_r[0] ^ ext_now[1]); // a leading b counts up

   // count write to a synchronized channel reaches every synchronized counter
   always_comb begin
      sync_hit_cnt = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         sync_hit_cnt = sync_hit_cnt | (hit[c] & sync_r[c]);
      end
   end

   assign sync_clr = |(clr_e & sync_r);

   generate
      for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
         tpu_chctl_t ctl_r;
         logic [CW-1:0] cnt_r;
         logic [CW-1:0] gra_r;
         logic [CW-1:0] grb_r;
         logic [CW-1:0] bra_r;
         logic [CW-1:0] brb_r;
         logic pa_r;
         logic pb_r;
         logic pa_prev_r;
         logic pb_prev_r;
         logic dn_r;
         logic dn_eff;
         logic tick;
         logic up;
         logic cap_a;
         logic cap_b;
         logic cmp_a;
         logic cmp_b;
         logic clr_now;
         logic wr_cnt;
         logic wr_here;
         logic bufa;
         logic bufb;
         logic tri_mode;
         logic quad_mode;
         logic rs_mode;

         if (ch >= 3) begin : g_buf
            assign bufa = mode_r.buf_en[2 * ch - 6];
            assign bufb = mode_r.buf_en[2 * ch - 5];
         end else begin : g_nobuf
            assign bufa = 1'b0;
            assign bufb = 1'b0;
         end

         assign tri_mode = (ch == 3) && mode_r.cmpl;
         assign quad_mode = (ch == 2) && mode_r.phase;
         assign rs_mode = (ch == 3) && mode_r.rsync;
         assign wr_here = go_wr & full16 & hit[ch];

         // count source select, gated by the channel start bit
         always_comb begin
            if (quad_mode) begin
               tick = start_r[ch] & q_chg;
            end else if (ctl_r.clk[2]) begin
               tick = start_r[ch] & ext_rise[ctl_r.clk[1:0]];
            end else begin
               tick = start_r[ch] & pre_en[ctl_r.clk[1:0]];
            end
         end

         // triangle direction turns at the a register and at zero
         assign dn_eff = dn_r ? (cnt_r != 16'h0000) : (cnt_r == gra_r);
         assign up = quad_mode ? q_up : (tri_mode ? ~dn_eff : 1'b1);

         // pwm treats both registers as compares
         assign cap_a = ~ctl_r.pwm & cap_hit(ctl_r.io_a, capture_compare_pin_a_i[ch], pa_prev_r);
         assign cap_b = ~ctl_r.pwm & cap_hit(ctl_r.io_b, capture_compare_pin_b_i[ch], pb_prev_r);
         assign cmp_a = tick & (ctl_r.pwm | ~ctl_r.io_a[2]) & (cnt_r == gra_r);
         assign cmp_b = tick & (ctl_r.pwm | ~ctl_r.io_b[2]) & (cnt_r == grb_r);
         assign evt_a[ch] = cmp_a | cap_a;
         assign evt_b[ch] = cmp_b | cap_b;

         // own clear source; triangle mode never clears, reset-sync clears on a
         assign clr_e[ch] = ~tri_mode & ((ctl_r.clr == CLR_A || rs_mode) & evt_a[ch]
                            | (ctl_r.clr == CLR_B) & evt_b[ch]);
         assign clr_now = clr_e[ch] | (sync_r[ch] & sync_clr);
         assign wr_cnt = go_wr & full16 & (sel == SEL_CNT) & (hit[ch] | (sync_r[ch] & sync_hit_cnt));
         assign ovf_e[ch] = tick & ~clr_now & ~wr_cnt
                            & (up ? (cnt_r == 16'hffff) : (cnt_r == 16'h0000));

         // counter: bus write beats clear, clear beats counting
         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               cnt_r <= CNT_RST;
               dn_r <= 1'b0;
            end else if (wr_cnt) begin
               cnt_r <= avs_writedata[CW-1:0];
            end else if (clr_now) begin
               cnt_r <= CNT_RST;
            end else if (tick) begin
               cnt_r <= up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
               dn_r <= tri_mode & dn_eff;
            end
         end

         // config and general registers; capture moves the old value to the buffer
         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               ctl_r <= '0;
               gra_r <= GR_RST;
               grb_r <= GR_RST;
               bra_r <= GR_RST;
               brb_r <= GR_RST;
            end else begin
               if (wr_here && sel == SEL_CTRL) begin
                  ctl_r <= tpu_chctl_t'(avs_writedata[CTL_W-1:0]);
               end
               if (wr_here && sel == SEL_GRA) begin
                  gra_r <= avs_writedata[CW-1:0];
               end else if (cap_a) begin
                  gra_r <= cnt_r;
               end else if (cmp_a && bufa) begin
                  gra_r <= bra_r;
               end
               if (wr_here && sel == SEL_GRB) begin
                  grb_r <= avs_writedata[CW-1:0];
               end else if (cap_b) begin
                  grb_r <= cnt_r;
               end else if (cmp_b && bufb) begin
                  grb_r <= brb_r;
               end
               if (ch >= 3 && wr_here && sel == SEL_BRA) begin
                  bra_r <= avs_writedata[CW-1:0];
               end else if (cap_a && bufa) begin
                  bra_r <= gra_r;
               end
               if (ch >= 3 && wr_here && sel == SEL_BRB) begin
                  brb_r <= avs_writedata[CW-1:0];
               end else if (cap_b && bufb) begin
                  brb_r <= grb_r;
               end
            end
         end

         // pin waveform state; channel 2 holds on a toggle setting
         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               pa_r <= 1'b0;
               pb_r <= 1'b0;
               pa_prev_r <= 1'b0;
               pb_prev_r <= 1'b0;
            end else begin
               pa_prev_r <= capture_compare_pin_a_i[ch];
               pb_prev_r <= capture_compare_pin_b_i[ch];
               if (ctl_r.pwm) begin
                  if (cmp_b) begin
                     pa_r <= 1'b0;
                  end else if (cmp_a) begin
                     pa_r <= 1'b1;
                  end
               end else if (cmp_a) begin
                  case (ctl_r.io_a)
                     IO_OUT0: pa_r <= 1'b0;
                     IO_OUT1: pa_r <= 1'b1;
                     IO_TOG: pa_r <= (ch == 2) ? pa_r : ~pa_r;
                     default: ;
                  endcase
               end
               if (!ctl_r.pwm && cmp_b) begin
                  case (ctl_r.io_b)
                     IO_OUT0: pb_r <= 1'b0;
                     IO_OUT1: pb_r <= 1'b1;
                     IO_TOG: pb_r <= (ch == 2) ? pb_r : ~pb_r;
                     default: ;
                  endcase
               end
            end
         end

         assign pa_s[ch] = pa_r;
         assign pb_s[ch] = pb_r;
         assign oea_s[ch] = ctl_r.pwm | (ctl_r.io_a != IO_OFF && !ctl_r.io_a[2] && !(ch == 2 && ctl_r.io_a == IO_TOG));
         assign oeb_s[ch] = ~ctl_r.pwm & ctl_r.io_b != IO_OFF & ~ctl_r.io_b[2] & ~(ch == 2 && ctl_r.io_b == IO_TOG);
         assign cnt_w[ch] = cnt_r;
         assign gra_w[ch] = gra_r;
         assign grb_w[ch] = grb_r;
         assign bra_w[ch] = bra_r;
         assign brb_w[ch] = brb_r;
         assign ctl_w[ch] = ctl_r;
      end
   endgenerate

   // three-phase pairs from channel 3's counter against b3, a4, b4
   assign special = mode_r.rsync | mode_r.cmpl;
   assign c3 = {1'b0, cnt_w[3]};
   assign dz = {9'h0, mode_r.dead};

   always_comb begin
      for (int k = 0; k < 3; k++) begin
         logic [CW:0] g;
         g = {1'b0, (k == 0) ? grb_w[3] : ((k == 1) ? gra_w[4] : grb_w[4])};
         if (mode_r.cmpl) begin
            pos[k] = (c3 + dz) < g; // dead band keeps the pair apart
            neg[k] = c3 > (g + dz);
         end else begin
            pos[k] = c3 < g;
            neg[k] = ~(c3 < g);
         end
      end
   end

   // registered pins; three-phase modes take over channels 3 and 4
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         capture_compare_pin_a_o <= '0;
         capture_compare_pin_b_o <= '0;
         capture_compare_pin_a_oe <= '0;
         capture_compare_pin_b_oe <= '0;
         ch4_inverted_out_a <= 1'b1;
         ch4_inverted_out_b <= 1'b1;
      end else if (special) begin
         capture_compare_pin_a_o <= {pos[1], pos[0], pa_s[2:0]};
         capture_compare_pin_b_o <= {pos[2], neg[0], pb_s[2:0]};
         capture_compare_pin_a_oe <= {2'b11, oea_s[2:0]};
         capture_compare_pin_b_oe <= {2'b11, oeb_s[2:0]};
         ch4_inverted_out_a <= neg[1];
         ch4_inverted_out_b <= neg[2];
      end else begin
         capture_compare_pin_a_o <= pa_s;
         capture_compare_pin_b_o <= pb_s;
         capture_compare_pin_a_oe <= oea_s;
         capture_compare_pin_b_oe <= oeb_s;
         ch4_inverted_out_a <= ~pa_s[4];
         ch4_inverted_out_b <= ~pb_s[4];
      end
   end

   // sticky status: a new event wins over a write-one clear
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         ev[3 * c + ST_A] = evt_a[c];
         ev[3 * c + ST_B] = evt_b[c];
         ev[3 * c + ST_OVF] = ovf_e[c];
      end
      stat_nxt = stat_r;
      if (go_wr && full16 && avs_address == ADDR_STAT) begin
         stat_nxt = stat_nxt & ~avs_writedata[NIRQ-1:0];
      end
      stat_nxt = stat_nxt | ev;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stat_r <= '0;
         irq_vec <= '0;
         irq <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         irq_vec <= stat_nxt & mask_r; // fifteen separate lines
         irq <= |(stat_nxt & mask_r);
      end
   end

   // one-cycle dma and pattern pulses for channels 0 to 3
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dma_req <= 4'h0;
         pattern_trig <= 4'h0;
      end else begin
         dma_req <= evt_a[3:0];
         pattern_trig <= evt_a[3:0] | evt_b[3:0];
      end
   end

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = waitreq_r;

endmodule

// ===== tb/test_five_channel_timer_pulse_unit.sv
// Purpose: self-checking bench for the timer pulse unit
// Assumes: waitrequest answers every request
// Notes: expected values come from the written data and the reset table
`timescale 1ns/1ps
module test_five_channel_timer_pulse_unit import tpu_pkg::*;;
   logic clk_sys = 0;
   logic nrst = 0;
   logic [7:0] addr = 0;
   logic rd = 0;
   logic wr = 0;
   logic [3:0] be = 4'hf;
   logic [31:0] wd = 0;
   logic [31:0] rdata, q;
   logic [31:0] seed = 32'he637d634;
   logic wreq, irq, inva, invb;
   logic [4:0] ao, aoe, bo, boe, la, lb;
   logic [4:0] da = 0;
   logic [3:0] ext = 0;
   logic [14:0] iv;
   logic [3:0] dma, pt;
   logic [15:0] gv [5];
   logic [15:0] g;
   int fails = 0, checked = 0, cyc = 0, ndma = 0, t0;
   always #4 clk_sys = ~clk_sys;
   tpu_timer_pulse_unit uut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(addr), .avs_read(rd),
      .avs_write(wr), .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdata),
      .avs_waitrequest(wreq), .ext_clock_in_a(ext[0]), .ext_clock_in_b(ext[1]), .ext_clock_in_c(ext[2]),
      .ext_clock_in_d(ext[3]), .capture_compare_pin_a_i(la), .capture_compare_pin_a_o(ao),
      .capture_compare_pin_a_oe(aoe), .capture_compare_pin_b_i(lb), .capture_compare_pin_b_o(bo),
      .capture_compare_pin_b_oe(boe), .ch4_inverted_out_a(inva), .ch4_inverted_out_b(invb),
      .irq(irq), .irq_vec(iv), .dma_req(dma), .pattern_trig(pt));
   tpu_pin_model pa (.oe(aoe), .o(ao), .drv(da), .lvl(la));
   tpu_pin_model pb (.oe(boe), .o(bo), .drv(5'h00), .lvl(lb));
   // cycle count, dma pulse count and the hang limit
   always @(posedge clk_sys) begin
      cyc++;
      if (dma[0] === 1'b1) ndma++;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [7:0] ca(input int c, input int s);
      return 8'(64 + 32 * c + 4 * s);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one bus cycle, held until waitrequest is seen low
   task automatic bus(input logic [7:0] a, input int w, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr <= 1'(w);
      rd <= !w;
      wd <= d;
      @(posedge clk_sys);
      while (wreq !== 1'b0) @(posedge clk_sys);
      q = rdata;
      wr <= 0;
      rd <= 0;
   endtask
   task automatic end_sim();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1;
      // reset values, then random words in general and buffer registers
      for (int c = 0; c < 5; c++) begin
         seed = lfsr(seed);
         gv[c] = seed[15:0];
         bus(ca(c, 1), 0, 0);
         chk(q, 0);
         bus(ca(c, 2), 0, 0);
         chk(q, 32'h0000ffff);
         bus(ca(c, 3), 1, {16'h0, gv[c]});
         bus(ca(c, 4), 1, {16'h0, gv[c]});
         bus(ca(c, 3), 0, 0);
         chk(q, {16'h0, gv[c]});
         bus(ca(c, 4), 0, 0);
         chk(q, c >= 3 ? {16'h0, gv[c]} : 32'h0000ffff);
      end
      // partial byte enable and an unmapped place are both ignored
      be <= 4'h1;
      bus(ca(0, 3), 1, 32'h1234);
      be <= 4'hf;
      bus(ca(0, 3), 0, 0);
      chk(q, {16'h0, gv[0]});
      bus(8'h3c, 1, 32'h5a5a);
      bus(8'h3c, 0, 0);
      chk(q, 0);
      // compare match sets the pin, clears the counter, period g+1
      g = 16'(8 + seed[4:0]);
      bus(ca(0, 2), 1, {16'h0, g});
      bus(ca(0, 0), 1, 32'({1'b0, CLR_A, IO_OFF, IO_OUT1, CLK_PHI}));
      bus(ADDR_MASK, 1, 32'h7fff);
      t0 = cyc;
      bus(ADDR_START, 1, 1);
      while (irq !== 1'b1) @(posedge clk_sys);
      chk(32'(cyc - t0 >= g && cyc - t0 <= g + 8), 1);
      // the pin register follows the status flag by one edge
      @(posedge clk_sys);
      chk(ao[0], 1);
      chk(aoe[0], 1);
      repeat (3 * (g + 1)) @(posedge clk_sys);
      chk(32'(ndma >= 3), 1);
      chk(iv[0], 1);
      // stop, then clear every flag by writing ones
      bus(ADDR_START, 1, 0);
      bus(ADDR_STAT, 1, 32'h7fff);
      repeat (3) @(posedge clk_sys);
      chk(irq, 0);
      // overflow while masked, then unmasked
      bus(ADDR_MASK, 1, 0);
      bus(ca(1, 1), 1, 32'hfffe);
      bus(ca(1, 0), 1, 0);
      bus(ADDR_START, 1, 2);
      repeat (6) @(posedge clk_sys);
      chk(irq, 0);
      bus(ADDR_STAT, 0, 0);
      chk(q[5], 1);
      bus(ADDR_MASK, 1, 32'h20);
      repeat (3) @(posedge clk_sys);
      chk(irq, 1);
      // capture on a rising edge of the channel 2 pin
      bus(ca(2, 0), 1, 32'({1'b0, CLR_NONE, IO_TOG, IO_CAP_R, CLK_PHI}));
      bus(ADDR_START, 1, 4);
      repeat (5) @(posedge clk_sys);
      da <= 5'h04;
      repeat (4) @(posedge clk_sys);
      bus(ca(2, 2), 0, 0);
      chk(q, 32'h5); // five ticks before the pin edge is seen
      bus(ADDR_STAT, 0, 0);
      chk(q[6], 1);
      // toggle is refused on channel 2, so pin b stays undriven
      chk(boe[2], 0);
      chk(32'({inva, invb}), 32'h3);
      // pwm on channel 1: high from match a to match b, period b+1
      bus(ca(1, 0), 1, 32'({1'b1, CLR_B, IO_OFF, IO_OFF, CLK_PHI}));
      bus(ca(1, 2), 1, 32'h4);
      bus(ca(1, 3), 1, 32'h9);
      bus(ca(1, 1), 1, 0);
      bus(ADDR_START, 1, 2);
      repeat (12) @(posedge clk_sys);
      t0 = 0;
      repeat (20) begin
         @(posedge clk_sys);
         t0 += ao[1];
      end
      chk(t0, 10);
      // channel 2 phase count: a leading b steps up once per edge
      bus(ca(2, 1), 1, 32'h100);
      bus(ADDR_MODE, 1, 1);
      bus(ADDR_START, 1, 4);
      for (int i = 0; i < 4; i++) begin
         ext <= 4'(8'h2d >> (2 * i)) & 4'h3;
         repeat (2) @(posedge clk_sys);
      end
      bus(ca(2, 1), 0, 0);
      chk(q, 32'h104);
      // a count write to one synchronized channel reaches the other
      bus(ADDR_SYNC, 1, 3);
      bus(ca(0, 1), 1, 32'h77);
      bus(ca(1, 1), 0, 0);
      chk(q, 32'h77);
      end_sim();
   end
endmodule
bind tpu_timer_pulse_unit tpu_asserts u_chk (.clk_sys(clk_sys), .nrst(nrst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .capture_compare_pin_a_oe(capture_compare_pin_a_oe), .irq(irq), .irq_vec(irq_vec),
   .dma_req(dma_req), .pattern_trig(pattern_trig));

// ===== tb/tpu_asserts.sv
// Purpose: bus and event checks on the timer pulse unit ports
// Assumes: one clock domain, reset active low
// Notes: wr_h remembers recent writes, the only cause of a falling flag
`timescale 1ns/1ps
module tpu_asserts import tpu_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // outputs
   input wire logic [NCH-1:0] capture_compare_pin_a_oe,
   input wire logic irq,
   input wire logic [NIRQ-1:0] irq_vec,
   input wire logic [3:0] dma_req,
   input wire logic [3:0] pattern_trig
);
   logic [2:0] wr_h;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // write history over the last three cycles
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_h <= 3'h0;
      end else begin
         wr_h <= {wr_h[1:0], avs_write};
      end
   end
   property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one) else $error("answer too long");
   property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   property p_idle; avs_waitrequest && !(avs_read || avs_write) |=> avs_waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("idle answer");
   property p_hi; !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_irq; irq == (|irq_vec); endproperty
   a_irq: assert property (p_irq) else $error("irq differs from vector");
   property p_dma; (dma_req & ~pattern_trig) == 4'h0; endproperty
   a_dma: assert property (p_dma) else $error("dma without trigger");
   property p_clr; |($past(irq_vec) & ~irq_vec) |-> |wr_h; endproperty
   a_clr: assert property (p_clr) else $error("flag fell unasked");
   property p_oe; $changed(capture_compare_pin_a_oe) |-> |wr_h; endproperty
   a_oe: assert property (p_oe) else $error("drive changed unasked");
endmodule

// ===== tb/tpu_pin_model.sv
// Purpose: far-side pin driver for the capture/compare pins
// Assumes: bench sets the outside level through drv
// Notes: a pin the design drives shows its value, so no contention is modelled
`timescale 1ns/1ps
module tpu_pin_model (
   // design side
   input wire logic [4:0] oe,
   input wire logic [4:0] o,
   // outside driver and resolved level
   input wire logic [4:0] drv,
   output logic [4:0] lvl
);
   // resolve the wire from the design enable, edges feed capture
   assign lvl = (oe & o) | (~oe & drv);
endmodule
